//--- rtl/ubr_uart.sv
// serial port with fractional baud generator and auto-baud measurement

// Behaviour
// R1 - baud equals clock over oversample, divisor, fraction
// R2 - software keeps multiply 1..15, add below it
// R3 - zero add value bypasses fractional stretch
// R4 - oversample_by_eight set: 8 samples, else 16
// R5 - software leaves fraction alone during traffic
// R6 - start bit runs auto-baud, self-clears
// R7 - auto-baud clears fifo, blocks and halts transmit
// R8 - mode 0 fall-to-fall, mode 1 fall-to-rise
// R9 - auto retry restarts at next falling edge
// R10 - counter overflow sets timeout flag if enabled
// R11 - success sets done flag if enabled, as divisor loads
// R12 - flags held until software writes clear
// R13 - software keeps add zero, divisor first
// R14 - start resets counter, shifter, fast rx clock; code resets the baud divider at start, fast pulses begin at the falling edge
// R15 - falling edge starts counting clock cycles
// R16 - sixteen fast shifter pulses capture start bit
// R17 - count loads divisor, reception then continues
// R18 - buffer read gives oldest, zero-padded character
// R19 - latch access selects divisor at 0x00/0x04
// R20 - holding write appends; sent lsb first
// R21 - sixteen-bit divisor, zero acts as one
// R22 - sixteen-deep fifos, triggers 1/4/8/14
// R23 - latch access is line control bit 7
// R24 - timeout enable bit 9, done bit 8
module ubr_uart
    import ubr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [5:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    input  wire logic        serial_rx_pin,
    output logic             serial_tx_pin,
    output logic             rx_trigger_hit,
    output logic             autobaud_event
);
    import ubr_pkg::*;

    // bits per character from the word length field
    function automatic logic [3:0] word_bits(input logic [1:0] wls);
        return 4'h5 + {2'b00, wls};
    endfunction

    logic [7:0]      divisor_low, divisor_high, line_ctrl;
    logic [9:0]      irq_enable;
    logic [3:0]      frac_add_value, frac_mul_value;
    logic            oversample_by_eight;
    logic [1:0]      rx_trig_sel;
    logic            autobaud_start, ab_mode, autobaud_auto_retry;
    logic            autobaud_timeout_flag, autobaud_done_flag;
    ubr_ab_state_t   ab_state;
    logic [15:0]     rate_count;
    logic [4:0]      ab_prescale, fast_left;
    logic            ab_load, ab_overflow, rx_prev;
    logic [15:0]     div_count, div_eff;
    logic [4:0]      frac_acc, frac_sum;
    logic            stretch, os_tick, rx_tick;
    logic [3:0]      os_last;
    logic [7:0]      tx_mem [FIFO_DEPTH];
    logic [7:0]      rx_mem [FIFO_DEPTH];
    logic [PTR_W:0]  tx_wp, tx_rp, rx_wp, rx_rp;
    logic [PTR_W:0]  rx_level;
    logic            latch_on, wr_data, rd_data, ab_write, ab_kick;
    logic            tx_push, tx_pop, rx_push, rx_pop;
    ubr_line_state_t tx_state, rx_state;
    logic [3:0]      tx_os, rx_os, tx_bit, rx_bit;
    logic [7:0]      tx_shift, rx_shift;
    logic            rx_fall, rx_rise;

    // register decode; latch access steers the shared offsets
    assign latch_on = line_ctrl[LC_LATCH_BIT];                 // [R23]
    assign wr_data  = reg_wr && reg_addr == OFF_DATA;
    assign rd_data  = reg_rd && reg_addr == OFF_DATA && !latch_on;
    assign ab_write = reg_wr && reg_addr == OFF_ABCTRL;
    assign ab_kick  = ab_write && reg_wdata[AB_START_BIT] && !autobaud_start;
    assign rx_fall  = rx_prev && !serial_rx_pin;
    assign rx_rise  = !rx_prev && serial_rx_pin;

    // control registers written by software
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_ctrl           <= 8'h00;
            irq_enable          <= 10'h000;
            frac_add_value      <= 4'h0;
            frac_mul_value      <= FD_MUL_RESET;
            oversample_by_eight <= 1'b0;
            rx_trig_sel         <= 2'h0;
            ab_mode             <= 1'b0;
            autobaud_auto_retry <= 1'b0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                OFF_IE: if (!latch_on) begin                   // [R19]
                    irq_enable <= reg_wdata[9:0];              // [R24]
                end
                OFF_LC: line_ctrl <= reg_wdata[7:0];
                OFF_II_FC: rx_trig_sel <= reg_wdata[FC_TRIG_LSB +: 2];
                OFF_FD: begin
                    frac_add_value      <= reg_wdata[FD_ADD_LSB +: 4];
                    frac_mul_value      <= reg_wdata[FD_MUL_LSB +: 4];
                    oversample_by_eight <= reg_wdata[FD_OVERSAMPLE_BY_EIGHT_BIT];
                end
                OFF_ABCTRL: begin
                    ab_mode             <= reg_wdata[AB_MODE_BIT];
                    autobaud_auto_retry <= reg_wdata[AB_RETRY_BIT];
                end
                default: ;
            endcase
        end
    end

    // divisor latches, loaded by software or by the measurement
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divisor_low  <= 8'h00;
            divisor_high <= 8'h00;
        end else if (ab_load) begin
            divisor_low  <= rate_count[7:0];                   // [R17]
            divisor_high <= rate_count[15:8];
        end else if (reg_wr && latch_on) begin
            if (reg_addr == OFF_DATA) divisor_low <= reg_wdata[7:0];
            if (reg_addr == OFF_IE) divisor_high <= reg_wdata[7:0];
        end
    end

    // baud tick: divisor period, stretched by the fractional accumulator
    assign div_eff = (divisor_high * DIV_HIGH_SCALE + divisor_low == 16'h0)
                   ? DIV_ZERO_AS                               // [R21]
                   : 16'(divisor_high * DIV_HIGH_SCALE + divisor_low);
    assign frac_sum = frac_acc + {1'b0, frac_add_value};
    assign os_tick  = (div_count >= div_eff - 16'h1) && !stretch;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_count <= 16'h0;
            frac_acc  <= 5'h0;
            stretch   <= 1'b0;
        end else if (ab_kick) begin
            div_count <= 16'h0;
            frac_acc  <= 5'h0;
            stretch   <= 1'b0;
        end else if (div_count >= div_eff - 16'h1) begin      // [R1]
            div_count <= 16'h0;
            if (stretch) begin
                stretch <= 1'b0;
            end else if (frac_add_value != 4'h0) begin        // [R3]
                if (frac_sum >= {1'b0, frac_mul_value}) begin
                    frac_acc <= frac_sum - {1'b0, frac_mul_value};
                    stretch  <= 1'b1;
                end else begin
                    frac_acc <= frac_sum;
                end
            end
        end else begin
            div_count <= div_count + 16'h1;
        end
    end

    // samples per bit minus one
    assign os_last = oversample_by_eight ? 4'h7 : 4'hF;        // [R4]

    // auto-baud measurement state machine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ab_state    <= AB_IDLE;
            autobaud_start <= 1'b0;
            rate_count  <= 16'h0;
            ab_prescale <= 5'h0;
            fast_left   <= 5'h0;
            ab_load     <= 1'b0;
            ab_overflow <= 1'b0;
            rx_prev     <= 1'b1;
        end else begin
            rx_prev     <= serial_rx_pin;
            ab_load     <= 1'b0;
            ab_overflow <= 1'b0;
            if (fast_left != 5'h0) fast_left <= fast_left - 5'h1;
            if (ab_write && !reg_wdata[AB_START_BIT]) begin
                autobaud_start <= 1'b0;                        // [R6]
                ab_state       <= AB_IDLE;
                fast_left      <= 5'h0;
            end else if (ab_kick) begin
                autobaud_start <= 1'b1;                        // [R6]
                ab_state       <= AB_WAIT;
                rate_count     <= 16'h0;                       // [R14]
                ab_prescale    <= 5'h0;
            end else begin
                unique case (ab_state)
                    AB_IDLE: ;
                    AB_WAIT: if (rx_fall) begin
                        ab_state    <= AB_MEASURE;             // [R15]
                        rate_count  <= 16'h0;
                        ab_prescale <= 5'h1; // edge cycle counts too
                        fast_left   <= FAST_PULSES;            // [R16]
                    end
                    AB_MEASURE: begin
                        if ((ab_mode && rx_rise) ||
                            (!ab_mode && rx_fall)) begin       // [R8]
                            ab_load        <= 1'b1;            // [R17]
                            autobaud_start <= 1'b0;
                            ab_state       <= AB_IDLE;
                        end else if (ab_prescale == (ab_mode
                                     ? {1'b0, os_last}
                                     : {os_last, 1'b1})) begin
                            ab_prescale <= 5'h0;
                            if (rate_count == RATE_MAX) begin
                                ab_overflow <= 1'b1;
                                // [R9]
                                ab_state <= autobaud_auto_retry
                                          ? AB_WAIT : AB_IDLE;
                                autobaud_start <= autobaud_auto_retry;
                            end else begin
                                rate_count <= rate_count + 16'h1;
                            end
                        end else begin
                            ab_prescale <= ab_prescale + 5'h1;
                        end
                    end
                    default: ab_state <= AB_IDLE;
                endcase
            end
        end
    end

    // sticky auto-baud flags; an event wins over a clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            autobaud_timeout_flag <= 1'b0;
            autobaud_done_flag    <= 1'b0;
        end else begin
            if (ab_overflow && irq_enable[IE_TIMEOUT_BIT]) begin
                autobaud_timeout_flag <= 1'b1;                 // [R10]
            end else if (ab_write && reg_wdata[AB_TIMEOUT_CLR_BIT]) begin
                autobaud_timeout_flag <= 1'b0;                 // [R12]
            end
            if (ab_load && irq_enable[IE_DONE_BIT]) begin
                autobaud_done_flag <= 1'b1;                    // [R11]
            end else if (ab_write && reg_wdata[AB_DONE_CLR_BIT]) begin
                autobaud_done_flag <= 1'b0;                    // [R12]
            end
        end
    end
    assign autobaud_event = autobaud_timeout_flag | autobaud_done_flag;

    // transmit fifo; writes refused while auto-baud runs
    assign tx_push = wr_data && !latch_on && !autobaud_start    // [R7]
                   && (tx_wp - tx_rp) != 5'(FIFO_DEPTH);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_wp <= '0;
            tx_rp <= '0;
        end else if (ab_kick || (reg_wr && reg_addr == OFF_II_FC
                                 && reg_wdata[FC_TXRST_BIT])) begin
            tx_wp <= '0;                                       // [R7]
            tx_rp <= '0;
        end else begin
            if (tx_push) begin
                tx_mem[tx_wp[PTR_W-1:0]] <= reg_wdata[7:0];    // [R20]
                tx_wp <= tx_wp + 5'h1;
            end
            if (tx_pop) tx_rp <= tx_rp + 5'h1;
        end
    end

    // transmitter, least significant bit first
    assign tx_pop = tx_state == LN_IDLE && tx_wp != tx_rp && !autobaud_start;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_state      <= LN_IDLE;
            tx_os         <= 4'h0;
            tx_bit        <= 4'h0;
            tx_shift      <= 8'h00;
            serial_tx_pin <= 1'b1;
        end else if (tx_pop) begin
            tx_state      <= LN_START;
            tx_shift      <= tx_mem[tx_rp[PTR_W-1:0]];
            tx_os         <= 4'h0;
            serial_tx_pin <= 1'b0;
        end else if (tx_state != LN_IDLE && os_tick
                     && !autobaud_start) begin                 // [R7]
            tx_os <= tx_os + 4'h1;
            if (tx_os == os_last) begin
                tx_os <= 4'h0;
                unique case (tx_state)
                    LN_START: begin
                        tx_state      <= LN_DATA;
                        tx_bit        <= 4'h0;
                        serial_tx_pin <= tx_shift[0];          // [R20]
                        tx_shift      <= {1'b0, tx_shift[7:1]};
                    end
                    LN_DATA: if (tx_bit == word_bits(line_ctrl[1:0]) - 4'h1)
                    begin
                        tx_state      <= LN_STOP;
                        tx_bit        <= 4'h0;
                        serial_tx_pin <= 1'b1;
                    end else begin
                        tx_bit        <= tx_bit + 4'h1;
                        serial_tx_pin <= tx_shift[0];
                        tx_shift      <= {1'b0, tx_shift[7:1]};
                    end
                    LN_STOP: begin
                        tx_bit <= tx_bit + 4'h1;
                        if (tx_bit == {3'h0, line_ctrl[LC_STOP_BIT]}) begin
                            tx_state <= LN_IDLE;
                        end
                    end
                    default: tx_state <= LN_IDLE;
                endcase
            end
        end
    end

    // receiver; fast pulses during the measured start bit
    assign rx_tick = (ab_state == AB_MEASURE) ? (fast_left != 5'h0)
                                              : os_tick;       // [R16]
    assign rx_push = rx_state == LN_STOP && rx_tick && rx_os == os_last
                   && (rx_wp - rx_rp) != 5'(FIFO_DEPTH);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_state <= LN_IDLE;
            rx_os    <= 4'h0;
            rx_bit   <= 4'h0;
            rx_shift <= 8'h00;
        end else if (ab_kick) begin
            rx_state <= LN_IDLE;                               // [R14]
            rx_shift <= 8'h00;
        end else if (ab_load) begin
            rx_state <= LN_DATA;                               // [R17]
            rx_os    <= 4'h0;
            rx_bit   <= ab_mode ? 4'h0 : 4'h1;
            rx_shift <= ab_mode ? 8'h00 : 8'h80;
        end else if (rx_state == LN_IDLE) begin
            if (rx_fall) begin
                rx_state <= LN_START;
                rx_os    <= 4'h0;
            end
        end else if (rx_tick) begin
            rx_os <= rx_os + 4'h1;
            if (rx_os == {1'b0, os_last[3:1]} && rx_state == LN_DATA) begin
                rx_shift <= {serial_rx_pin, rx_shift[7:1]};
            end
            if (rx_state == LN_START && rx_os == {1'b0, os_last[3:1]}
                && serial_rx_pin) begin
                rx_state <= LN_IDLE;                           // false start
            end else if (rx_os == os_last) begin
                rx_os <= 4'h0;
                unique case (rx_state)
                    LN_START: begin
                        rx_state <= LN_DATA;
                        rx_bit   <= 4'h0;
                    end
                    LN_DATA: if (rx_bit == word_bits(line_ctrl[1:0]) - 4'h1)
                    begin
                        rx_state <= LN_STOP;
                    end else begin
                        rx_bit <= rx_bit + 4'h1;
                    end
                    LN_STOP: rx_state <= LN_IDLE;
                    default: rx_state <= LN_IDLE;
                endcase
            end
        end
    end

    // receive fifo; character aligned down to bit 0, upper bits zero
    assign rx_pop   = rd_data && rx_wp != rx_rp;
    assign rx_level = rx_wp - rx_rp;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_wp <= '0;
            rx_rp <= '0;
        end else if (ab_kick || (reg_wr && reg_addr == OFF_II_FC
                                 && reg_wdata[FC_RXRST_BIT])) begin
            rx_wp <= '0;                                       // [R7]
            rx_rp <= '0;
        end else begin
            if (rx_push) begin
                rx_mem[rx_wp[PTR_W-1:0]] <= rx_shift >>
                    (4'h8 - word_bits(line_ctrl[1:0]));        // [R18]
                rx_wp <= rx_wp + 5'h1;
            end
            if (rx_pop) rx_rp <= rx_rp + 5'h1;                 // [R18]
        end
    end

    // receive trigger level
    always_comb begin
        unique case (rx_trig_sel)                              // [R22]
            2'h0: rx_trigger_hit = rx_level >= 5'h01;
            2'h1: rx_trigger_hit = rx_level >= 5'h04;
            2'h2: rx_trigger_hit = rx_level >= 5'h08;
            2'h3: rx_trigger_hit = rx_level >= 5'h0E;
        endcase
    end

    // registered read data, one cycle after the read strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                OFF_DATA: reg_rdata <= latch_on                // [R19]
                    ? {24'h0, divisor_low}
                    : {24'h0, rx_mem[rx_rp[PTR_W-1:0]]
                              & {8{rx_wp != rx_rp}}};
                OFF_IE: reg_rdata <= latch_on ? {24'h0, divisor_high}
                                              : {22'h0, irq_enable};
                OFF_II_FC: reg_rdata <= {22'h0, autobaud_timeout_flag,
                    autobaud_done_flag, FIFO_EN_BITS, 5'h0,
                    !autobaud_event};
                OFF_LC: reg_rdata <= {24'h0, line_ctrl};
                OFF_LS: reg_rdata <= {25'h0,
                    tx_wp == tx_rp && tx_state == LN_IDLE,
                    tx_wp == tx_rp, 4'h0, rx_wp != rx_rp};
                OFF_ABCTRL: reg_rdata <= {29'h0, autobaud_auto_retry,
                    ab_mode, autobaud_start};                  // [R6]
                OFF_FD: reg_rdata <= {23'h0, oversample_by_eight,
                    frac_mul_value, frac_add_value};
                default: reg_rdata <= 32'h0;
            endcase
        end
    end
endmodule

//--- rtl/ubr_pkg.sv
// constants for the baud generator, auto-baud and register map
package ubr_pkg;
    // register offsets
    localparam logic [5:0] OFF_DATA    = 6'h00; // rx buffer / tx hold / div low
    localparam logic [5:0] OFF_IE      = 6'h04; // irq enable / div high
    localparam logic [5:0] OFF_II_FC   = 6'h08; // irq id read, fifo ctrl write
    localparam logic [5:0] OFF_LC      = 6'h0C;
    localparam logic [5:0] OFF_LS      = 6'h14;
    localparam logic [5:0] OFF_ABCTRL  = 6'h20;
    localparam logic [5:0] OFF_FD      = 6'h28;
    // line control fields
    localparam int LC_LATCH_BIT        = 7;
    localparam int LC_STOP_BIT         = 2;
    // interrupt enable fields
    localparam int IE_TIMEOUT_BIT      = 9;
    localparam int IE_DONE_BIT         = 8;
    // auto-baud control fields
    localparam int AB_START_BIT        = 0;
    localparam int AB_MODE_BIT         = 1;
    localparam int AB_RETRY_BIT        = 2;
    localparam int AB_DONE_CLR_BIT     = 8;
    localparam int AB_TIMEOUT_CLR_BIT  = 9;
    // fractional divider fields
    localparam int FD_ADD_LSB          = 0;
    localparam int FD_MUL_LSB          = 4;
    localparam int FD_OVERSAMPLE_BY_EIGHT_BIT        = 8;
    localparam logic [3:0] FD_MUL_RESET = 4'h1;
    // fifo control fields
    localparam int FC_RXRST_BIT        = 1;
    localparam int FC_TXRST_BIT        = 2;
    localparam int FC_TRIG_LSB         = 6;
    // sizes and counts
    localparam int FIFO_DEPTH          = 16;
    localparam int PTR_W               = 4;
    localparam int DIV_W               = 16;
    localparam logic [4:0] OS_SIXTEEN  = 5'h10;
    localparam logic [4:0] OS_EIGHT    = 5'h08;
    localparam logic [4:0] FAST_PULSES = 5'h10;
    localparam logic [8:0] DIV_HIGH_SCALE = 9'h100; // divisor = 256*high+low
    localparam logic [15:0] DIV_ZERO_AS = 16'h0001;
    localparam logic [15:0] RATE_MAX   = 16'hFFFF;
    localparam logic [1:0] FIFO_EN_BITS = 2'h3;

    typedef enum logic [1:0] {
        AB_IDLE    = 2'b00,
        AB_WAIT    = 2'b01,
        AB_MEASURE = 2'b10
    } ubr_ab_state_t;

    typedef enum logic [1:0] {
        LN_IDLE  = 2'b00,
        LN_START = 2'b01,
        LN_DATA  = 2'b10,
        LN_STOP  = 2'b11
    } ubr_line_state_t;
endpackage

//--- dv/ubr_uart_sva.sv
// port assertions for the serial port block
module ubr_uart_sva
    import ubr_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [5:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        serial_rx_pin,
    input wire logic        serial_tx_pin,
    input wire logic        rx_trigger_hit,
    input wire logic        autobaud_event
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // write aimed at auto-baud control
    wire ab_wr = reg_wr && reg_addr == OFF_ABCTRL;
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("rdata moved");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 6'h3C
        |=> reg_rdata == 32'h0) else $error("unmapped read");
    a_flag_sticky: assert property (autobaud_event && !ab_wr
        |=> autobaud_event) else $error("flag lost");
    a_flag_clear: assert property (ab_wr && reg_wdata[9:8] == 2'h3
        && !reg_wdata[0] |=> !autobaud_event) else $error("flag kept");
    a_id_fields: assert property (reg_rd && reg_addr == OFF_II_FC |=>
        reg_rdata[7:6] == 2'h3 && reg_rdata[0] != $past(autobaud_event)
        && |reg_rdata[9:8] == $past(autobaud_event)) else $error("id");
    a_reset_idle: assert property ($fell(rst) |-> serial_tx_pin
        && !autobaud_event && !rx_trigger_hit) else $error("reset");
    a_start_min: assert property ($fell(serial_tx_pin) |->
        !serial_tx_pin [*8]) else $error("short start bit");
    a_busy_status: assert property (reg_rd && reg_addr == OFF_LS
        && !serial_tx_pin |=> !reg_rdata[6]) else $error("idle flag");
    c_done: cover property (autobaud_event);
    c_rx_read: cover property (reg_rd && reg_addr == OFF_DATA);
    c_tx_frame: cover property ($fell(serial_tx_pin));
endmodule
bind ubr_uart ubr_uart_sva chk (.clk, .rst, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .serial_rx_pin, .serial_tx_pin,
    .rx_trigger_hit, .autobaud_event);

//--- dv/ubr_line_model.sv
// far-end serial equipment: sends frames, decodes the transmitter
module ubr_line_model (
    input  wire logic clk,
    input  wire logic tx,
    output logic      rx
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rx = 1'b1;
    // start low, lsb first, stop high; line idles high
    task automatic send(input logic [7:0] d, input int n, bt);
        for (int i = -1; i <= n; i++) begin
            rx <= i < 0 ? 1'b0 : i == n ? 1'b1 : d[i];
            repeat (bt) @(posedge clk);
        end
        // let the receiver finish its stop bit, leave off the edge
        repeat (2) @(posedge clk);
        #1;
    endtask
    // mid-bit sampler; bit 8 set on missing start or bad stop
    task automatic get(input int bt, output logic [8:0] d);
        d = 9'h100;
        for (int k = 0; k < 4000 && tx; k++) @(posedge clk);
        if (!tx) begin
            repeat (bt / 2) @(posedge clk);
            for (int i = 0; i < 9; i++) begin
                repeat (bt) @(posedge clk);
                d[i] = i < 8 ? tx : !tx;
            end
            // frame fully out before the rate may change
            repeat (bt) @(posedge clk);
        end
        #1;
    endtask
endmodule

//--- dv/tb_top.sv
// self-checking bench for the baud and auto-baud serial port
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ubr_pkg::*;
    logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
    logic [5:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0, rdata, seed = 40;
    logic        rx_pin, tx_pin, trig, ev;
    logic [8:0]  g;
    logic [7:0]  b;
    int          fail_count = 0, compares = 0;
    // 125 MHz clock
    always #4 clk = ~clk;
    ubr_uart DUT (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata(rdata), .serial_rx_pin(rx_pin), .serial_tx_pin(tx_pin),
        .rx_trigger_hit(trig), .autobaud_event(ev));
    ubr_line_model far (.clk, .tx(tx_pin), .rx(rx_pin));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(input logic [31:0] v, e);
        compares++;
        if (v !== e) begin
            fail_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, v, e);
        end
    endtask
    // one access, strobe for one edge, then a gap; reads compare masked
    task automatic acc(input logic w, input logic [5:0] a,
                       input logic [31:0] d, m = 0, e = 0);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(posedge clk);
        #1 reg_wr = 0;
        reg_rd = 0;
        @(posedge clk);
        #1 if (!w) chk(rdata & m, e);
    endtask
    task automatic setdiv(input logic [7:0] d, input logic [31:0] f);
        acc(1, OFF_LC, 32'h83);
        acc(1, OFF_DATA, d);
        acc(1, OFF_IE, 0);
        acc(1, OFF_LC, 32'h3);
        acc(1, OFF_FD, f);
    endtask
    task automatic results();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        logic [31:0] fd[3] = '{32'h10, 32'h110, 32'h121};
        logic [7:0]  dv[3] = '{8'h1, 8'h0, 8'h2};
        int          bt[3] = '{16, 8, 24};
        repeat (16) @(posedge clk);
        #1 rst = 0;
        acc(0, OFF_IE, 0, '1, 0);
        acc(0, OFF_II_FC, 0, '1, 32'hC1);
        acc(0, 6'h3C, 0, '1, 0);
        b = rnd();
        setdiv(b, 32'h10);
        acc(1, OFF_LC, 32'h83);
        acc(1, OFF_IE, b ^ 8'hFF);
        acc(0, OFF_IE, 0, '1, b ^ 8'hFF);
        acc(0, OFF_DATA, 0, '1, b);
        acc(1, OFF_LC, 32'h3);
        acc(1, OFF_IE, 32'h3FF);
        acc(0, OFF_IE, 0, '1, 32'h3FF);
        // transmit at three oversample and fraction settings
        for (int i = 0; i < 3; i++) begin
            setdiv(dv[i], fd[i]);
            b = rnd();
            acc(1, OFF_DATA, b);
            far.get(bt[i], g);
            chk(g, b);
            if (g[8]) results();
        end
        // receive, fifo reset, short characters
        setdiv(8'h1, 32'h10);
        far.send(b, 8, 16);
        chk(trig, 1);
        acc(1, OFF_II_FC, 32'h2);
        chk(trig, 0);
        acc(0, OFF_DATA, 0, '1, 0);
        far.send(b, 8, 16);
        acc(0, OFF_DATA, 0, '1, b);
        acc(1, OFF_LC, 32'h0);
        far.send(b, 5, 16);
        acc(0, OFF_DATA, 0, '1, b & 8'h1F);
        // auto-baud in both measuring modes
        for (int m = 0; m < 2; m++) begin
            setdiv(8'h7, 32'h10);
            acc(1, OFF_ABCTRL, m * 2 + 1);
            b = m ? 8'h41 : 8'h61;
            far.send(b, 8, 16 * (m + 2));
            acc(0, OFF_ABCTRL, 0, 32'h1, 0);
            chk(ev, 1);
            acc(1, OFF_LC, 32'h83);
            acc(0, OFF_DATA, 0, '1, m + 2);
            acc(1, OFF_LC, 32'h3);
            acc(0, OFF_DATA, 0, '1, b);
            acc(1, OFF_ABCTRL, 32'h300);
            chk(ev, 0);
        end
        // auto-baud start freezes and refuses the transmitter
        acc(1, OFF_DATA, 8'h55);
        acc(1, OFF_ABCTRL, 32'h1);
        acc(1, OFF_DATA, 8'hAA);
        chk(tx_pin, 0);
        acc(0, OFF_LS, 0, 32'h60, 32'h20);
        acc(1, OFF_ABCTRL, 32'h0);
        repeat (600) @(posedge clk);
        #1;
        acc(0, OFF_LS, 0, 32'h60, 32'h60);
        results();
    end
    // hang guard
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        results();
    end
endmodule
